// ---- shared/lpr_pkg.sv ----
// Constants for the line-port relay and status pin block.
// Assumes a 25 MHz system clock and an IOM-2 style link on its own clock.
package lpr_pkg;
   localparam int          LPR_PORTS     = 4;
   localparam int          LPR_RELAYS    = 4;
   localparam int          LPR_STATS     = 2;
   // System clock and symbol clock rates
   localparam int          LPR_MCLK_HZ   = 25_000_000;
   localparam int          LPR_TXCLK_HZ  = 120_000;
   localparam logic [24:0] LPR_ACC_MOD   = 25'(LPR_MCLK_HZ);
   localparam logic [24:0] LPR_ACC_STEP  = 25'(2 * LPR_TXCLK_HZ);
   // Single pulse test spacing
   localparam int          LPR_PULSE_US  = 1000;
   localparam int          LPR_PULSE_CYC =
      LPR_PULSE_US * (LPR_MCLK_HZ / 1_000_000);
   // Line symbol codes
   localparam logic [1:0]  LPR_SYM_ZERO  = 2'h0;
   localparam logic [1:0]  LPR_SYM_PLUS  = 2'h1;
   // IOM-2 slot layout, bit index within a 32 bit slot
   localparam logic [4:0]  LPR_MON_FIRST = 5'h10;
   localparam logic [4:0]  LPR_MON_LAST  = 5'h17;
   localparam logic [4:0]  LPR_MX_BIT    = 5'h1f;
   // Monitor byte opcodes in the upper nibble
   localparam logic [3:0]  LPR_OP_RELAY  = 4'ha;
   localparam logic [3:0]  LPR_OP_STAT   = 4'h5;
   // Register map, byte addresses
   localparam logic [7:0]  LPR_REG_CTRL  = 8'h00;
   localparam logic [7:0]  LPR_REG_RELAY = 8'h04;
   localparam logic [7:0]  LPR_REG_STAT  = 8'h08;
   localparam logic [7:0]  LPR_REG_CMDS  = 8'h0c;
   localparam logic [31:0] LPR_CTRL_RST  = 32'h0000_0000;
endpackage : lpr_pkg

// ---- hdl/lpr_pins.sv ----
// Relay driver, status pin, symbol clock and pulse test logic of four
// line ports. Assumes IOM-2 link clocked by i_dcl (two edges per bit),
// frame start flagged by i_fsc, and a plain register port on i_mclk.
`timescale 1ns/10ps

// Operation
// - Four relay outputs per port, from command bits
// - Hardware reset drives all relay outputs low
// - C/I reset leaves relay outputs unchanged
// - Async low reset clears all four ports
// - Slot select picks slots 0-3 or 4-7
// - Status inputs reported in monitor message
// - 120 kHz symbol clock per channel
// - Test mode sends +1 every 1 ms
// - Each port slot carries 32 bits
module lpr_pins #(
   parameter int P_PULSE_CYC = lpr_pkg::LPR_PULSE_CYC
) (
   input  wire logic        i_mclk,             // System clock, 25 MHz
   input  wire logic        i_arst_n,           // Pin reset, async, low
   input  wire logic        i_dcl,              // IOM-2 data clock
   input  wire logic        i_fsc,              // IOM-2 frame sync
   input  wire logic        i_din,              // IOM-2 data in
   output logic             o_dout,             // IOM-2 data out
   output logic             o_dout_oe,          // Drive enable for o_dout
   input  wire logic        i_slot_sel,         // Slot group select pin
   input  wire logic [1:0]  i_port0_stat_in,    // Port 0 status pins
   input  wire logic [1:0]  i_port1_stat_in,    // Port 1 status pins
   input  wire logic [1:0]  i_port2_stat_in,    // Port 2 status pins
   input  wire logic [1:0]  i_port3_stat_in,    // Port 3 status pins
   input  wire logic        i_single_pulse_test_en, // Test mode pin
   output logic [3:0]       o_relay_drv_p0,     // Port 0 relays D..A
   output logic [3:0]       o_relay_drv_p1,     // Port 1 relays D..A
   output logic [3:0]       o_relay_drv_p2,     // Port 2 relays D..A
   output logic [3:0]       o_relay_drv_p3,     // Port 3 relays D..A
   output logic [3:0]       o_tx_symbol_clk_ch, // Symbol clocks ch 3..0
   output logic [7:0]       o_tx_sym,           // Symbols, 2 bits per ch
   input  wire logic [7:0]  i_addr,             // Register byte address
   input  wire logic [31:0] i_wdata,            // Register write data
   input  wire logic        i_wr,               // Write strobe
   input  wire logic        i_rd,               // Read strobe
   output logic [31:0]      o_rdata             // Read data, next cycle
);
   import lpr_pkg::*;

   // ---------------- Link domain ----------------
   logic       dcl_rst_m_r;
   logic       dcl_rst_n;
   logic [9:0] pos_r;
   logic [9:0] pos;
   logic [8:0] bit_idx;
   logic [3:0] slot;
   logic [4:0] sbit;
   logic       ours;
   logic       sel_m_r;
   logic       sel_s_r;
   logic [7:0] stat_lm_r;
   logic [7:0] stat_ls_r;
   logic [7:0] mon_sh_r;
   logic [1:0] cmd_port_r;
   logic [3:0] cmd_bits_r;
   logic       cmd_tgl_r;
   logic       dout_r;
   logic       dout_oe_r;
   logic [3:0] drv_slot_r;
   logic       drv_sel_r;
   logic [7:0] tx_byte;
   logic [7:0] stat_pins;

   assign stat_pins = {i_port3_stat_in, i_port2_stat_in,
                       i_port1_stat_in, i_port0_stat_in};

   // Reset release synchronised to the link clock
   always_ff @(posedge i_dcl or negedge i_arst_n) begin
      if (!i_arst_n) begin
         dcl_rst_m_r <= 1'b0;
         dcl_rst_n   <= 1'b0;
      end else begin
         dcl_rst_m_r <= 1'b1;
         dcl_rst_n   <= dcl_rst_m_r;
      end
   end

   always_ff @(posedge i_dcl or negedge dcl_rst_n) begin
      if (!dcl_rst_n) begin
         sel_m_r   <= 1'b0;
         sel_s_r   <= 1'b0;
         stat_lm_r <= 8'h00;
         stat_ls_r <= 8'h00;
      end else begin
         sel_m_r   <= i_slot_sel;
         sel_s_r   <= sel_m_r;
         stat_lm_r <= stat_pins;
         stat_ls_r <= stat_lm_r;
      end
   end

   // Half-bit position in frame; two link edges per bit
   assign pos     = i_fsc ? 10'h000 : pos_r;
   assign bit_idx = pos[9:1];
   assign slot    = bit_idx[8:5];
   assign sbit    = bit_idx[4:0];
   assign ours    = (slot[3:2] == {1'b0, sel_s_r});

   always_ff @(posedge i_dcl or negedge dcl_rst_n) begin
      if (!dcl_rst_n) begin
         pos_r <= 10'h000;
      end else begin
         pos_r <= pos + 10'h001;
      end
   end

   // Receive: monitor byte, then MX low validates relay command
   always_ff @(posedge i_dcl or negedge dcl_rst_n) begin
      if (!dcl_rst_n) begin
         mon_sh_r   <= 8'h00;
         cmd_port_r <= 2'h0;
         cmd_bits_r <= 4'h0;
         cmd_tgl_r  <= 1'b0;
      end else if (pos[0] && ours) begin
         if (sbit >= LPR_MON_FIRST && sbit <= LPR_MON_LAST) begin
            mon_sh_r <= {mon_sh_r[6:0], i_din};
         end
         // C/I codes, reset included, never reach relay state
         if (sbit == LPR_MX_BIT && !i_din &&
             mon_sh_r[7:4] == LPR_OP_RELAY) begin
            cmd_port_r <= slot[1:0];
            cmd_bits_r <= mon_sh_r[3:0];
            cmd_tgl_r  <= ~cmd_tgl_r;
         end
      end
   end

   // Transmit: status byte in monitor field, MX driven active
   assign tx_byte = {LPR_OP_STAT, 2'b00,
                     stat_ls_r[{slot[1:0], 1'b0} +: 2]};

   always_ff @(posedge i_dcl or negedge dcl_rst_n) begin
      if (!dcl_rst_n) begin
         dout_r     <= 1'b1;
         dout_oe_r  <= 1'b0;
         drv_slot_r <= 4'h0;
         drv_sel_r  <= 1'b0;
      end else if (!pos[0]) begin
         drv_slot_r <= slot;
         drv_sel_r  <= sel_s_r;
         if (ours && sbit >= LPR_MON_FIRST && sbit <= LPR_MON_LAST) begin
            dout_r    <= tx_byte[~sbit[2:0]];
            dout_oe_r <= 1'b1;
         end else if (ours && sbit == LPR_MX_BIT) begin
            dout_r    <= 1'b0;
            dout_oe_r <= 1'b1;
         end else begin
            dout_r    <= 1'b1;
            dout_oe_r <= 1'b0;
         end
      end
   end

   assign o_dout    = dout_r;
   assign o_dout_oe = dout_oe_r;

   // ---------------- System domain ----------------
   logic        tgl_m_r;
   logic        tgl_s_r;
   logic        tgl_d_r;
   logic        cmd_evt;
   logic [3:0]  relay_r [LPR_PORTS];
   logic [15:0] relay_flat;
   logic [7:0]  stat_m_r;
   logic [7:0]  stat_s_r;
   logic        tsp_m_r;
   logic        tsp_s_r;
   logic [31:0] ctrl_r;
   logic [15:0] cmds_r;
   logic [31:0] rdata_r;
   logic        test_en;
   logic [31:0] pcnt_r;
   logic        pulse_due;
   logic [3:0]  sclk_r;
   logic [3:0]  stick;
   logic [3:0]  armed_r;
   logic [1:0]  sym_r [LPR_PORTS];
   logic [24:0] acc_r [LPR_PORTS];

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         tgl_m_r  <= 1'b0;
         tgl_s_r  <= 1'b0;
         tgl_d_r  <= 1'b0;
         stat_m_r <= 8'h00;
         stat_s_r <= 8'h00;
         tsp_m_r  <= 1'b0;
         tsp_s_r  <= 1'b0;
      end else begin
         tgl_m_r  <= cmd_tgl_r;
         tgl_s_r  <= tgl_m_r;
         tgl_d_r  <= tgl_s_r;
         stat_m_r <= stat_pins;
         stat_s_r <= stat_m_r;
         tsp_m_r  <= i_single_pulse_test_en;
         tsp_s_r  <= tsp_m_r;
      end
   end

   // Command port and bits stay still for a slot after the toggle
   assign cmd_evt = tgl_s_r ^ tgl_d_r;

   // Relays cleared only by the pin reset
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         for (int p = 0; p < LPR_PORTS; p++) begin
            relay_r[p] <= 4'h0;
         end
      end else if (cmd_evt) begin
         relay_r[cmd_port_r] <= cmd_bits_r;
      end
   end

   assign relay_flat     = {relay_r[3], relay_r[2], relay_r[1], relay_r[0]};
   assign o_relay_drv_p0 = relay_r[0];
   assign o_relay_drv_p1 = relay_r[1];
   assign o_relay_drv_p2 = relay_r[2];
   assign o_relay_drv_p3 = relay_r[3];

   // Register port
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ctrl_r <= LPR_CTRL_RST;
      end else if (i_wr && i_addr == LPR_REG_CTRL) begin
         ctrl_r <= {31'h0, i_wdata[0]};
      end
   end

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cmds_r <= 16'h0000;
      end else if (i_wr && i_addr == LPR_REG_CMDS) begin
         cmds_r <= cmd_evt ? 16'h0001 : 16'h0000;
      end else if (cmd_evt) begin
         cmds_r <= cmds_r + 16'h0001;
      end
   end

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rdata_r <= 32'h0000_0000;
      end else if (i_rd) begin
         case (i_addr)
            LPR_REG_CTRL:  rdata_r <= ctrl_r;
            LPR_REG_RELAY: rdata_r <= {16'h0000, relay_flat};
            LPR_REG_STAT:  rdata_r <= {24'h000000, stat_s_r};
            LPR_REG_CMDS:  rdata_r <= {16'h0000, cmds_r};
            default:       rdata_r <= 32'h0000_0000;
         endcase
      end else begin
         rdata_r <= 32'h0000_0000;
      end
   end

   assign o_rdata = rdata_r;

   // Pulse test timing, pin or control bit
   assign test_en   = tsp_s_r | ctrl_r[0];
   assign pulse_due = (pcnt_r == 32'(P_PULSE_CYC - 1));

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pcnt_r <= 32'h0000_0000;
      end else if (!test_en || pulse_due) begin
         pcnt_r <= 32'h0000_0000;
      end else begin
         pcnt_r <= pcnt_r + 32'h0000_0001;
      end
   end

   // Per channel symbol clock and test symbol
   for (genvar c = 0; c < LPR_PORTS; c++) begin : g_ch
      localparam logic [24:0] C_START = 25'(c * (LPR_MCLK_HZ / 4));
      assign stick[c] = (acc_r[c] + LPR_ACC_STEP >= LPR_ACC_MOD) &&
                        !sclk_r[c];

      always_ff @(posedge i_mclk or negedge i_arst_n) begin
         if (!i_arst_n) begin
            acc_r[c]  <= C_START;
            sclk_r[c] <= 1'b0;
         end else if (acc_r[c] + LPR_ACC_STEP >= LPR_ACC_MOD) begin
            acc_r[c]  <= acc_r[c] + LPR_ACC_STEP - LPR_ACC_MOD;
            sclk_r[c] <= ~sclk_r[c];
         end else begin
            acc_r[c]  <= acc_r[c] + LPR_ACC_STEP;
         end
      end

      // Armed by the 1 ms tick, fired at next symbol start
      always_ff @(posedge i_mclk or negedge i_arst_n) begin
         if (!i_arst_n) begin
            armed_r[c] <= 1'b0;
            sym_r[c]   <= LPR_SYM_ZERO;
         end else begin
            if (pulse_due && test_en) begin
               armed_r[c] <= 1'b1;
            end else if (stick[c] || !test_en) begin
               armed_r[c] <= 1'b0;
            end
            if (stick[c] && armed_r[c] && test_en) begin
               sym_r[c] <= LPR_SYM_PLUS;
            end else if (stick[c] || !test_en) begin
               sym_r[c] <= LPR_SYM_ZERO;
            end
         end
      end

      assign o_tx_symbol_clk_ch[c] = sclk_r[c];
      assign o_tx_sym[2*c +: 2]    = sym_r[c];
   end

   // ---------------- Checks ----------------
   logic        post_rst_r;
   logic [7:0]  half_cnt_r;
   logic [31:0] since_r;
   logic        sym0_d_r;

   // Spacing counted from the start of the previous pulse
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         post_rst_r <= 1'b0;
         half_cnt_r <= 8'h00;
         since_r    <= 32'h0000_0000;
         sym0_d_r   <= 1'b0;
      end else begin
         sym0_d_r   <= (sym_r[0] == LPR_SYM_PLUS);
         post_rst_r <= 1'b1;
         half_cnt_r <= (sclk_r[0] != o_tx_symbol_clk_ch[0]) ? 8'h00
                       : (acc_r[0] + LPR_ACC_STEP >= LPR_ACC_MOD) ? 8'h00
                       : half_cnt_r + 8'h01;
         since_r    <= (sym_r[0] == LPR_SYM_PLUS && !sym0_d_r)
                       ? 32'h0000_0000 : since_r + 32'h0000_0001;
      end
   end

   a_relay_reset_low: assert property (
      @(posedge i_mclk) disable iff (!i_arst_n)
      !post_rst_r |-> relay_flat == 16'h0000)
      else $error("relays not low after reset");

   a_relay_cmd_apply: assert property (
      @(posedge i_mclk) disable iff (!i_arst_n)
      cmd_evt |=> relay_r[cmd_port_r] == cmd_bits_r)
      else $error("relay command not applied");

   a_relay_hold_val: assert property (
      @(posedge i_mclk) disable iff (!i_arst_n)
      !cmd_evt |=> $stable(relay_flat))
      else $error("relay changed without command");

   a_symclk_half_period: assert property (
      @(posedge i_mclk) disable iff (!i_arst_n)
      (acc_r[0] + LPR_ACC_STEP >= LPR_ACC_MOD) |->
         (half_cnt_r == 8'd103 || half_cnt_r == 8'd104))
      else $error("symbol clock half period wrong");

   a_pulse_needs_test: assert property (
      @(posedge i_mclk) disable iff (!i_arst_n)
      $rose(sym_r[0] == LPR_SYM_PLUS) |-> $past(test_en))
      else $error("pulse sent outside test mode");

   a_pulse_spacing_min: assert property (
      @(posedge i_mclk) disable iff (!i_arst_n)
      $rose(sym_r[0] == LPR_SYM_PLUS) && post_rst_r |->
         since_r >= 32'(P_PULSE_CYC - LPR_MCLK_HZ / LPR_TXCLK_HZ - 2))
      else $error("test pulses too close");

   a_stat_read_back: assert property (
      @(posedge i_mclk) disable iff (!i_arst_n)
      i_rd && i_addr == LPR_REG_STAT |=>
         o_rdata == {24'h000000, $past(stat_s_r)})
      else $error("status read mismatch");

   a_drive_own_slot: assert property (
      @(posedge i_dcl) disable iff (!dcl_rst_n)
      dout_oe_r |-> drv_slot_r[3:2] == {1'b0, drv_sel_r})
      else $error("driving outside own slots");

endmodule : lpr_pins

// ---- verification/lpr_iom_model.sv ----
// IOM-2 controller model: link clock, frame sync, downstream commands
// and capture of upstream monitor bytes. Assumes 256 bit frames.
`timescale 1ns/10ps
module lpr_iom_model (
   output logic             o_dcl,    // Link clock, 30 ns
   output logic             o_fsc,    // Frame sync
   output logic             o_din,    // Downstream data
   input  wire logic        i_dout,   // Upstream data
   input  wire logic        i_oe,     // Upstream drive enable
   input  wire logic [7:0]  i_cmd_v,  // Command per slot
   input  wire logic [63:0] i_cmd_b,  // Monitor byte per slot
   input  wire logic [7:0]  i_mx_hi,  // MX sent high per slot
   output logic [15:0]      o_frames, // Frame count
   output logic [63:0]      o_rx_b,   // Monitor bytes seen
   output logic [7:0]       o_rx_mx,  // MX bits seen
   output logic [7:0]       o_rx_oe   // Slots driven last frame
);
   logic [8:0]  hb_r = 9'h1f0;
   logic [7:0]  v_r = 8'h0, mx_r = 8'h0, oe_r = 8'h0;
   logic [63:0] b_r = 64'h0;
   wire  [2:0]  s = hb_r[8:6];
   wire  [4:0]  pos = hb_r[5:1];
   wire         up = i_oe ? i_dout : 1'b1; // Pull-up on a released line
   initial begin
      o_dcl = 1'b0;
      o_fsc = 1'b0;
      o_din = 1'b1;
      o_frames = 16'h0;
      o_rx_b = 64'h0;
      o_rx_mx = 8'h0;
      o_rx_oe = 8'h0;
   end
   always #15 o_dcl = ~o_dcl;
   always @(posedge o_dcl) begin
      hb_r <= hb_r + 9'h1;
      o_fsc <= (hb_r == 9'h1ff);
      if (hb_r[0]) begin
         if (i_oe)
            oe_r[s] <= 1'b1;
         if (pos[4:3] == 2'h2)
            o_rx_b[{s, ~pos[2:0]}] <= up;
         if (pos == 5'h1f)
            o_rx_mx[s] <= up;
      end else if (v_r[s] && pos[4:3] == 2'h2) begin
         o_din <= b_r[{s, ~pos[2:0]}];
      end else if (pos == 5'h1f) begin
         o_din <= ~v_r[s] | mx_r[s];
      end else begin
         o_din <= 1'($urandom); // Data and C/I bits
      end
      if (hb_r == 9'h1ff) begin
         v_r <= i_cmd_v;
         b_r <= i_cmd_b;
         mx_r <= i_mx_hi;
         o_frames <= o_frames + 16'h1;
         o_rx_oe <= oe_r | {i_oe, 7'h0};
         oe_r <= 8'h0;
      end
   end
endmodule : lpr_iom_model

// ---- verification/test_lpr_pins.sv ----
// Testbench for the line port relay and status pin block.
// Registers and pins driven on i_mclk; link side from the model.
`timescale 1ns/10ps
module test_lpr_pins;
   import lpr_pkg::*;
   localparam int PC = 500;
   logic i_mclk = 1'b0, i_arst_n = 1'b0, slot_sel = 1'b0, single_pulse_test_en = 1'b0;
   logic wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
   logic [7:0] addr = 8'h0, stat = 8'h0, cmd_v = 8'h0, mx_hi = 8'h0;
   logic [31:0] wdata = 32'h0;
   logic [63:0] cmd_b = 64'h0;
   logic [15:0] rl_last = 16'h0, cur = 16'h0;
   wire logic [31:0] rdata;
   wire logic [63:0] rx_b;
   wire logic [15:0] relay, frames;
   wire logic [7:0] sym, rx_mx, rx_oe;
   wire logic [3:0] sclk;
   wire logic dcl, fsc, din, dout, oe;
   logic [31:0] rdq[$];
   logic [15:0] rlq[$];
   int err_total = 0, samples_checked = 0, ncmd = 0;
   always #20 i_mclk = ~i_mclk;
   lpr_pins #(.P_PULSE_CYC(PC)) i_lpr_pins (
      .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_dcl(dcl), .i_fsc(fsc),
      .i_din(din), .o_dout(dout), .o_dout_oe(oe), .i_slot_sel(slot_sel),
      .i_port0_stat_in(stat[1:0]), .i_port1_stat_in(stat[3:2]),
      .i_port2_stat_in(stat[5:4]), .i_port3_stat_in(stat[7:6]),
      .i_single_pulse_test_en(single_pulse_test_en), .o_relay_drv_p0(relay[3:0]),
      .o_relay_drv_p1(relay[7:4]), .o_relay_drv_p2(relay[11:8]),
      .o_relay_drv_p3(relay[15:12]), .o_tx_symbol_clk_ch(sclk),
      .o_tx_sym(sym), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
      .i_rd(rd), .o_rdata(rdata));
   lpr_iom_model i_lpr_iom_model (
      .o_dcl(dcl), .o_fsc(fsc), .o_din(din), .i_dout(dout), .i_oe(oe),
      .i_cmd_v(cmd_v), .i_cmd_b(cmd_b), .i_mx_hi(mx_hi), .o_frames(frames),
      .o_rx_b(rx_b), .o_rx_mx(rx_mx), .o_rx_oe(rx_oe));
   task automatic chk(input logic [31:0] got, exp, input string m);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   task automatic results;
      $display("Checked %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : results
   task automatic wait_fr(input int n);
      logic [15:0] f;
      f = frames;
      for (int i = 0; i < 1000 * n; i++) begin
         @(posedge i_mclk);
         if (frames == f + 16'(n))
            return;
      end
      err_total++;
      $display("BAD %0t wait for frames timed out", $time);
      results();
   endtask : wait_fr
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge i_mclk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
      @(posedge i_mclk);
      rdq.push_back(e);
      addr <= a;
      rd <= 1'b1;
      @(posedge i_mclk);
      rd <= 1'b0;
   endtask : rd_reg
   task automatic send(input logic [63:0] b, input logic [7:0] m);
      cmd_v <= 8'hff;
      cmd_b <= b;
      mx_hi <= m;
      wait_fr(1);
      cmd_v <= 8'h0;
      wait_fr(1);
      repeat (8) @(posedge i_mclk);
   endtask : send
   // Commands to all eight slots; only the selected group may act
   task automatic round(input logic sel);
      logic [63:0] b;
      logic [3:0]  n;
      slot_sel <= sel;
      stat <= 8'($urandom);
      wait_fr(2);
      for (int s = 0; s < 8; s++) begin
         n = cur[4*(s%4)+:4] ^ (4'h1 + 4'($urandom_range(14)));
         b[8*s+:8] = {LPR_OP_RELAY, n};
         if (s / 4 == sel) begin
            cur[4*(s%4)+:4] = n;
            rlq.push_back(cur);
         end
      end
      send(b, 8'h0);
      ncmd += 4;
      chk({24'h0, rx_oe}, sel ? 32'hf0 : 32'h0f, "own slots");
      chk({24'h0, rx_mx}, sel ? 32'h0f : 32'hf0, "mx bits");
      for (int p = 0; p < 4; p++)
         chk({24'h0, rx_b[8*(p+4*sel)+:8]},
             {24'h0, LPR_OP_STAT, 2'h0, stat[2*p+:2]}, "status");
      rd_reg(LPR_REG_RELAY, {16'h0, cur});
      rd_reg(LPR_REG_STAT, {24'h0, stat});
      rd_reg(LPR_REG_CMDS, 32'(ncmd));
   endtask : round
   task automatic refuse(input logic [3:0] op, input logic [7:0] m);
      logic [63:0] b;
      for (int s = 0; s < 8; s++)
         b[8*s+:8] = {op, ~cur[4*(s%4)+:4]};
      send(b, m);
      rd_reg(LPR_REG_RELAY, {16'h0, cur});
   endtask : refuse
   always @(posedge i_mclk) begin
      rd_d <= rd;
      if (rd_d)
         chk(rdata, rdq.pop_front(), "read data");
      if (i_arst_n && relay !== rl_last) begin
         rl_last <= relay;
         if (rlq.size() == 0)
            chk({16'h0, relay}, {16'h0, rl_last}, "relay moved");
         else
            chk({16'h0, relay}, {16'h0, rlq.pop_front()}, "relay");
      end
   end
   initial begin
      int k, t0, n, w, d;
      logic pv;
      void'($urandom(32'hc98e5565));
      repeat (6) @(posedge i_mclk);
      i_arst_n <= 1'b1;
      repeat (4) @(posedge i_mclk);
      rd_reg(LPR_REG_CTRL, LPR_CTRL_RST);
      rd_reg(LPR_REG_RELAY, 32'h0);
      rd_reg(LPR_REG_CMDS, 32'h0);
      rd_reg(8'h10, 32'h0);
      $display("reset values done");
      round(1'b0);
      round(1'b1);
      round(1'b0);
      $display("relay commands done");
      refuse(LPR_OP_RELAY, 8'hff);
      refuse(4'h3, 8'h0);
      refuse(LPR_OP_STAT, 8'h0);
      rd_reg(LPR_REG_CMDS, 32'(ncmd));
      wr_reg(LPR_REG_CMDS, 32'h0);
      ncmd = 0;
      wr_reg(8'h10, 32'hffff_ffff);
      rd_reg(LPR_REG_CMDS, 32'h0);
      rd_reg(LPR_REG_CTRL, 32'h0);
      $display("refused commands done");
      for (int c = 0; c < 4; c++) begin
         n = 0;
         k = 0;
         t0 = 0;
         pv = sclk[c];
         while (n < 13 && k < 4000) begin
            @(posedge i_mclk);
            k++;
            if (sclk[c] && !pv) begin
               if (n == 0)
                  t0 = k;
               n++;
            end
            pv = sclk[c];
         end
         d = k - t0;
         chk(32'(d > 2498 && d < 2502), 32'h1, "clock rate");
      end
      $display("symbol clocks done");
      for (int m = 0; m < 2; m++) begin
         if (m == 0)
            single_pulse_test_en <= 1'b1;
         else
            wr_reg(LPR_REG_CTRL, 32'h1);
         n = 0;
         w = 0;
         for (int i = 0; i < 10 * PC; i++) begin
            @(posedge i_mclk);
            chk({24'h0, sym & 8'haa}, 32'h0, "symbol code");
            if (sym[1:0] == LPR_SYM_PLUS) begin
               w++;
            end else if (w > 0) begin
               chk(32'(w > 207 && w < 211), 32'h1, "pulse width");
               n++;
               w = 0;
            end
         end
         chk(32'(n > 8 && n < 12), 32'h1, "pulse count");
         single_pulse_test_en <= 1'b0;
         wr_reg(LPR_REG_CTRL, 32'h0);
         repeat (PC) @(posedge i_mclk);
         for (int i = 0; i < PC; i++) begin
            @(posedge i_mclk);
            chk({24'h0, sym}, 32'h0, "pulse when off");
         end
      end
      $display("pulse test done");
      @(posedge i_mclk);
      #7;
      if (cur != 16'h0)
         rlq.push_back(16'h0);
      cur = 16'h0;
      ncmd = 0;
      i_arst_n = 1'b0;
      #3;
      chk({12'h0, relay, sclk}, 32'h0, "outputs in reset");
      repeat (6) @(posedge i_mclk);
      i_arst_n <= 1'b1;
      repeat (4) @(posedge i_mclk);
      rd_reg(LPR_REG_RELAY, 32'h0);
      round(1'b1);
      $display("pin reset done");
      repeat (4) @(posedge i_mclk);
      chk(32'(rlq.size() + rdq.size()), 32'h0, "results left over");
      results();
   end
endmodule : test_lpr_pins
